// ==== core/rx_dbg_monitor.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "rx_dbg_regs.svh"

module rx_dbg_monitor
    import rx_dbg_pkg::*;
#(
    parameter int LANES = 8
)
(
    input  wire logic          clock_i,
    input  wire logic          rst_b_i,
    input  wire reg_req_s      req_i,
    output logic [31:0]        rdata_o,
    input  wire lane_status_s  lanes_i,
    input  wire logic          sysref_i,
    output logic               irq_o,
    output logic [7:0]         lmfc_count_o
);

    if (LANES < 1 || LANES > 8) begin : g_lane_check
        $error("LANES must lie between 1 and 8");
    end

    // Lanes above LANES read as zero
    localparam logic [7:0] LANE_MASK = 8'((16'h0001 << LANES) - 16'h0001);

    monitor_state_s q;
    monitor_state_s d;

    logic        sysref_seen;
    logic [2:0]  events;
    logic [2:0]  clear_bits;
    logic [31:0] fs_word;
    logic [31:0] fifo_word;
    logic [31:0] align_word;

    lmfc_tracker u_lmfc_tracker (
        .clock_i       (clock_i),
        .rst_b_i       (rst_b_i),
        .sysref_i      (sysref_i),
        .enable_i      (q.sub1_en),
        .lmfc_last_i   (q.lmfc_last),
        .sysref_seen_o (sysref_seen),
        .lmfc_count_o  (lmfc_count_o)
    );

    always_comb begin
        fs_word = `RST_STATUS;
        for (int i = 0; i < 8; i++) begin
            fs_word[2*i +: 2] = q.lanes.fs_state[i];
        end
    end

    always_comb begin
        fifo_word = `RST_STATUS;
        fifo_word[`POS_HI_FIELD +: 8] = q.lanes.drained;
        fifo_word[`POS_LO_FIELD +: 8] = q.lanes.overflowing;
    end

    always_comb begin
        align_word = `RST_STATUS;
        align_word[`POS_HI_FIELD +: 8] = q.lanes.config_begun;
        align_word[`POS_LO_FIELD +: 8] = q.lanes.payload;
    end

    always_comb begin
        d = q;

        // Straight copy every cycle, nothing sticky in the status view
        for (int i = 0; i < 8; i++) begin
            if (LANE_MASK[i]) begin
                d.lanes.fs_state[i] = lanes_i.fs_state[i];
            end else begin
                d.lanes.fs_state[i] = 2'b00;
            end
        end
        d.lanes.drained      = lanes_i.drained & LANE_MASK;
        d.lanes.overflowing  = lanes_i.overflowing & LANE_MASK;
        d.lanes.config_begun = lanes_i.config_begun & LANE_MASK;
        d.lanes.payload      = lanes_i.payload & LANE_MASK;

        // Interrupt events: the tracker's SYSREF detect, and rising edges of the overflow and payload copies
        events = 3'h0;
        events[`IRQ_SYSREF] = sysref_seen;
        events[`IRQ_OVERFLOW] = |(d.lanes.overflowing & ~q.lanes.overflowing);
        events[`IRQ_PAYLOAD] = |(d.lanes.payload & ~q.lanes.payload);

        clear_bits = 3'h0;
        if (req_i.wr && req_i.addr == `OFS_IRQ_CLEAR) begin
            clear_bits = req_i.wdata[2:0];
        end
        // Set wins over a clear in the same cycle so no event is lost
        d.irq_stat = (q.irq_stat & ~clear_bits) | events;

        if (req_i.wr) begin
            unique case (req_i.addr)
                `OFS_IRQ_ENABLE: begin
                    d.irq_en = req_i.wdata[2:0];
                end
                `OFS_LINK_CTRL: begin
                    d.sub1_en   = req_i.wdata[`POS_SUB1_EN];
                    d.lmfc_last = req_i.wdata[`POS_LMFC_LAST +: 8];
                end
                // Status words ignore writes
                default: begin
                end
            endcase
        end

        // Read data stand for one cycle only
        d.rdata = `RST_STATUS;
        if (req_i.rd) begin
            unique case (req_i.addr)
                `OFS_FRAME_SYNC: begin
                    d.rdata = fs_word;
                end
                `OFS_LANE_FIFO: begin
                    d.rdata = fifo_word;
                end
                `OFS_ALIGN_PHASE: begin
                    d.rdata = align_word;
                end
                `OFS_IRQ_STATUS: begin
                    d.rdata[2:0] = q.irq_stat;
                end
                `OFS_IRQ_ENABLE: begin
                    d.rdata[2:0] = q.irq_en;
                end
                `OFS_LINK_CTRL: begin
                    d.rdata[`POS_SUB1_EN] = q.sub1_en;
                    d.rdata[`POS_LMFC_LAST +: 8] = q.lmfc_last;
                end
                `OFS_LMFC_COUNT: begin
                    d.rdata[7:0] = lmfc_count_o;
                end
                // Unmapped and write-only offsets read zero
                default: begin
                end
            endcase
        end

        if (q.warm != 2'h3) begin
            d.warm = q.warm + 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q           <= '0;
            q.irq_en    <= `RST_IRQ_EN;
            q.sub1_en   <= `RST_SUB1_EN;
            q.lmfc_last <= `RST_LMFC_LAST;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign irq_o   = |(q.irq_stat & q.irq_en);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_fs_lane0: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[1:0] == $past(lanes_i.fs_state[0], 2))
        else $error("lane 0 frame sync field wrong");
    a_fs_lane2: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[5:4] == ($past(lanes_i.fs_state[2], 2) & {2{LANE_MASK[2]}}))
        else $error("lane 2 frame sync field wrong");
    a_empty_field: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_LANE_FIFO
        |=> rdata_o[23:16] == ($past(lanes_i.drained, 2) & LANE_MASK))
        else $error("buffer empty field wrong");
    a_full_field: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_LANE_FIFO
        |=> rdata_o[7:0] == ($past(lanes_i.overflowing, 2) & LANE_MASK))
        else $error("buffer full field wrong");
    a_config_field: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_ALIGN_PHASE
        |=> rdata_o[23:16] == ($past(lanes_i.config_begun, 2) & LANE_MASK))
        else $error("alignment config field wrong");
    a_payload_field: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_ALIGN_PHASE
        |=> rdata_o[7:0] == ($past(lanes_i.payload, 2) & LANE_MASK))
        else $error("payload phase field wrong");
    a_reserved_zero: assert property (
        req_i.rd && (req_i.addr == `OFS_LANE_FIFO || req_i.addr == `OFS_ALIGN_PHASE)
        |=> rdata_o[31:24] == 8'h00 && rdata_o[15:8] == 8'h00)
        else $error("reserved bits not zero");
    a_no_latch: assert property (
        $fell(lanes_i.overflowing[0]) |=> !q.lanes.overflowing[0])
        else $error("status bit held after source dropped");
    a_irq_sticky: assert property (
        sysref_seen |=> q.irq_stat[`IRQ_SYSREF])
        else $error("sysref event lost");

    // Remaining frame sync lanes; fields of absent lanes read zero
    a_fs_lane1: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[3:2] == ($past(lanes_i.fs_state[1], 2) & {2{LANE_MASK[1]}}))
        else $error("lane 1 frame sync field wrong");
    a_fs_lane3: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[7:6] == ($past(lanes_i.fs_state[3], 2) & {2{LANE_MASK[3]}}))
        else $error("lane 3 frame sync field wrong");
    a_fs_lane4: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[9:8] == ($past(lanes_i.fs_state[4], 2) & {2{LANE_MASK[4]}}))
        else $error("lane 4 frame sync field wrong");
    a_fs_lane5: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[11:10] == ($past(lanes_i.fs_state[5], 2) & {2{LANE_MASK[5]}}))
        else $error("lane 5 frame sync field wrong");
    a_fs_lane6: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[13:12] == ($past(lanes_i.fs_state[6], 2) & {2{LANE_MASK[6]}}))
        else $error("lane 6 frame sync field wrong");
    a_fs_lane7: assert property (
        q.warm == 2'h3 && req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[15:14] == ($past(lanes_i.fs_state[7], 2) & {2{LANE_MASK[7]}}))
        else $error("lane 7 frame sync field wrong");
    a_fs_upper_zero: assert property (
        req_i.rd && req_i.addr == `OFS_FRAME_SYNC
        |=> rdata_o[31:16] == 16'h0000)
        else $error("frame sync upper bits not zero");

    // Register file reads and writes
    a_rdata_idle: assert property (
        !req_i.rd |=> rdata_o == 32'h0000_0000)
        else $error("read data held past its cycle");
    a_irq_read: assert property (
        req_i.rd && req_i.addr == `OFS_IRQ_STATUS
        |=> rdata_o == {29'h0, $past(q.irq_stat)})
        else $error("interrupt status read wrong");
    a_en_read: assert property (
        req_i.rd && req_i.addr == `OFS_IRQ_ENABLE
        |=> rdata_o == {29'h0, $past(q.irq_en)})
        else $error("interrupt enable read wrong");
    a_ctrl_read: assert property (
        req_i.rd && req_i.addr == `OFS_LINK_CTRL
        |=> rdata_o == {16'h0, $past(q.lmfc_last), 7'h00, $past(q.sub1_en)})
        else $error("link control read wrong");
    a_count_read: assert property (
        req_i.rd && req_i.addr == `OFS_LMFC_COUNT
        |=> rdata_o == {24'h0, $past(lmfc_count_o)})
        else $error("counter read wrong");
    a_clear_read: assert property (
        req_i.rd && req_i.addr == `OFS_IRQ_CLEAR
        |=> rdata_o == 32'h0000_0000)
        else $error("clear register not write-only");
    a_en_write: assert property (
        req_i.wr && req_i.addr == `OFS_IRQ_ENABLE
        |=> q.irq_en == $past(req_i.wdata[2:0]))
        else $error("interrupt enable write lost");
    a_ctrl_write: assert property (
        req_i.wr && req_i.addr == `OFS_LINK_CTRL
        |=> q.sub1_en == $past(req_i.wdata[`POS_SUB1_EN])
            && q.lmfc_last == $past(req_i.wdata[`POS_LMFC_LAST +: 8]))
        else $error("link control write lost");

    // Sticky interrupt flags: set wins, only a clear write drops a bit
    a_irq_clear: assert property (
        req_i.wr && req_i.addr == `OFS_IRQ_CLEAR && req_i.wdata[`IRQ_SYSREF]
        && !sysref_seen |=> !q.irq_stat[`IRQ_SYSREF])
        else $error("sysref status not cleared");
    a_ovf_clear: assert property (
        req_i.wr && req_i.addr == `OFS_IRQ_CLEAR && req_i.wdata[`IRQ_OVERFLOW]
        && (lanes_i.overflowing & LANE_MASK & ~q.lanes.overflowing) == 8'h00
        |=> !q.irq_stat[`IRQ_OVERFLOW])
        else $error("overflow status not cleared");
    a_irq_hold: assert property (
        q.irq_stat[`IRQ_OVERFLOW]
        && !(req_i.wr && req_i.addr == `OFS_IRQ_CLEAR && req_i.wdata[`IRQ_OVERFLOW])
        |=> q.irq_stat[`IRQ_OVERFLOW])
        else $error("overflow status dropped without clear");
    a_pay_hold: assert property (
        q.irq_stat[`IRQ_PAYLOAD]
        && !(req_i.wr && req_i.addr == `OFS_IRQ_CLEAR && req_i.wdata[`IRQ_PAYLOAD])
        |=> q.irq_stat[`IRQ_PAYLOAD])
        else $error("payload status dropped without clear");
    a_ovf_event: assert property (
        (lanes_i.overflowing & LANE_MASK & ~q.lanes.overflowing) != 8'h00
        |=> q.irq_stat[`IRQ_OVERFLOW])
        else $error("overflow rise not recorded");
    a_pay_event: assert property (
        (lanes_i.payload & LANE_MASK & ~q.lanes.payload) != 8'h00
        |=> q.irq_stat[`IRQ_PAYLOAD])
        else $error("payload rise not recorded");
    a_irq_rises: assert property (
        req_i.wr && req_i.addr == `OFS_IRQ_ENABLE && (req_i.wdata[2:0] & q.irq_stat) != 3'h0
        |=> irq_o)
        else $error("interrupt not raised by enable");
    a_irq_low: assert property (
        q.irq_en == 3'h0 |-> !irq_o)
        else $error("interrupt raised while all masked");

    // Status copies follow their sources every cycle
    a_copy_drained: assert property (
        q.warm == 2'h3
        |=> q.lanes.drained == ($past(lanes_i.drained) & LANE_MASK))
        else $error("buffer empty copy wrong");
    a_copy_full: assert property (
        q.warm == 2'h3
        |=> q.lanes.overflowing == ($past(lanes_i.overflowing) & LANE_MASK))
        else $error("buffer full copy wrong");
    a_copy_config: assert property (
        q.warm == 2'h3
        |=> q.lanes.config_begun == ($past(lanes_i.config_begun) & LANE_MASK))
        else $error("alignment config copy wrong");
    a_copy_payload: assert property (
        q.warm == 2'h3
        |=> q.lanes.payload == ($past(lanes_i.payload) & LANE_MASK))
        else $error("payload phase copy wrong");
    a_copy_fs0: assert property (
        q.warm == 2'h3
        |=> q.lanes.fs_state[0] == $past(lanes_i.fs_state[0]))
        else $error("lane 0 frame sync copy wrong");

    // Counter behaviour as seen beside the register file
    a_det_needs_en: assert property (
        sysref_seen |-> $past(q.sub1_en))
        else $error("sysref detected while subclass 1 off");
    a_sub1_off: assert property (
        !q.sub1_en |=> !sysref_seen)
        else $error("sysref acted while subclass 1 off");
    a_count_wrap: assert property (
        lmfc_count_o >= q.lmfc_last && !sysref_seen
        |=> lmfc_count_o == 8'h00)
        else $error("counter missed its wrap");
    a_count_step: assert property (
        lmfc_count_o < q.lmfc_last && !sysref_seen
        |=> lmfc_count_o == $past(lmfc_count_o) + 8'h01)
        else $error("counter did not step");

endmodule

// ==== shared/rx_dbg_regs.svh ====
`ifndef RX_DBG_REGS_SVH
`define RX_DBG_REGS_SVH

// Byte offsets of the register window
`define OFS_FRAME_SYNC   12'h0f4
`define OFS_LANE_FIFO    12'h0f8
`define OFS_ALIGN_PHASE  12'h0fc
`define OFS_IRQ_STATUS   12'h100
`define OFS_IRQ_ENABLE   12'h104
`define OFS_IRQ_CLEAR    12'h108
`define OFS_LINK_CTRL    12'h10c
`define OFS_LMFC_COUNT   12'h110

// Field positions
`define POS_HI_FIELD     16
`define POS_LO_FIELD     0
`define POS_SUB1_EN      0
`define POS_LMFC_LAST    8
`define IRQ_SYSREF       0
`define IRQ_OVERFLOW     1
`define IRQ_PAYLOAD      2

// Reset values
`define RST_STATUS       32'h0000_0000
`define RST_IRQ_EN       3'h0
`define RST_SUB1_EN      1'b1
`define RST_LMFC_LAST    8'h07

// Link clock cycles from internal SYSREF sample to counter reset
`define SYSREF_TO_RESET_CYC 2

`endif

// ==== shared/rx_dbg_pkg.sv ====
package rx_dbg_pkg;

    typedef struct packed {
        logic [7:0][1:0] fs_state;
        logic [7:0]      drained;
        logic [7:0]      overflowing;
        logic [7:0]      config_begun;
        logic [7:0]      payload;
    } lane_status_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic       smp;
        logic       prev;
        logic       det;
        logic [7:0] cnt;
    } tracker_state_s;

    typedef struct packed {
        lane_status_s lanes;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_en;
        logic         sub1_en;
        logic [7:0]   lmfc_last;
        logic [31:0]  rdata;
        logic [1:0]   warm;
    } monitor_state_s;

endpackage

// ==== core/lmfc_tracker.sv ====
`timescale 1ns/10ps
`include "rx_dbg_regs.svh"

module lmfc_tracker
    import rx_dbg_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic       sysref_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] lmfc_last_i,
    output logic            sysref_seen_o,
    output logic [7:0]      lmfc_count_o
);

    tracker_state_s q;
    tracker_state_s d;

    always_comb begin
        d      = q;
        // Sampling register; upstream pipeline stages share this clock
        d.smp  = sysref_i;
        d.prev = q.smp;
        d.det  = q.smp & ~q.prev & enable_i;
        if (q.det) begin
            d.cnt = 8'h00;
        end else if (q.cnt >= lmfc_last_i) begin
            d.cnt = 8'h00;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sysref_seen_o = q.det;
    assign lmfc_count_o  = q.cnt;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_sysref_resets: assert property (q.det |=> q.cnt == 8'h00)
        else $error("counter not reset after sysref detect");
    a_fixed_latency: assert property (
        q.det |-> $past(sysref_i, 2) && !$past(sysref_i, 3))
        else $error("sysref to detect latency not fixed");
    a_two_cycles: assert property (
        $rose(q.smp) && enable_i |=> q.det ##1 q.cnt == 8'h00)
        else $error("counter reset not two cycles after sample");

endmodule

// ==== dv/adc_link_side.sv ====
`timescale 1ns/10ps

module adc_link_side
    import rx_dbg_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         rst_b_i,
    input  wire lane_status_s lanes_set_i,
    input  wire logic         sysref_req_i,
    output lane_status_s      lanes_o,
    output logic              sysref_o
);
    logic stage_q;

    // Two stages for SYSREF, one for the lane status, on the link clock: long routing closed in timing, latency stays fixed
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_q  <= 1'b0;
            sysref_o <= 1'b0;
            lanes_o  <= '0;
        end else begin
            stage_q  <= sysref_req_i;
            sysref_o <= stage_q;
            lanes_o  <= lanes_set_i;
        end
    end
endmodule

// ==== dv/rx_dbg_monitor_bench.sv ====
`timescale 1ns/10ps
`include "rx_dbg_regs.svh"

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got); end end

module rx_dbg_monitor_bench
    import rx_dbg_pkg::*;
    ;
    typedef struct packed {
        lane_status_s l;
        logic [31:0]  fs;
        logic [31:0]  fifo;
        logic [31:0]  algn;
    } row_s;

    logic         clock_i, rst_b_i, sref_req, sysref_w, irq_w;
    reg_req_s     req;
    lane_status_s lanes_set, lanes_w;
    logic [31:0]  rdata_w;
    logic [7:0]   lmfc_w;
    int           num_errors, samples_checked;
    row_s         rows [4];

    rx_dbg_monitor #(.LANES(8)) uut (
        .clock_i      (clock_i),
        .rst_b_i      (rst_b_i),
        .req_i        (req),
        .rdata_o      (rdata_w),
        .lanes_i      (lanes_w),
        .sysref_i     (sysref_w),
        .irq_o        (irq_w),
        .lmfc_count_o (lmfc_w)
    );

    adc_link_side far_side (
        .clock_i      (clock_i),
        .rst_b_i      (rst_b_i),
        .lanes_set_i  (lanes_set),
        .sysref_req_i (sref_req),
        .lanes_o      (lanes_w),
        .sysref_o     (sysref_w)
    );

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        req <= {a, d, 2'b10};
        @(posedge clock_i);
        req <= '0;
    endtask

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(posedge clock_i);
        req <= {a, 32'h0, 2'b01};
        @(posedge clock_i);
        req <= '0;
        #1 `CHK(nm, exp, rdata_w)
    endtask

    // Counter must read 0 two edges after the edge that samples SYSREF, then count and wrap
    task automatic sysref_run(input int last, input bit chk);
        int n;
        @(posedge clock_i);
        sref_req <= 1'b1;
        @(posedge clock_i);
        sref_req <= 1'b0;
        for (n = 0; n < 20 && sysref_w !== 1'b1; n++) @(posedge clock_i);
        if (n == 20) begin
            num_errors++;
            end_sim();
        end
        repeat (2) @(posedge clock_i);
        for (n = 0; n < 6 && chk; n++) begin
            #1 `CHK("lmfc_count", 8'(n % (last + 1)), lmfc_w)
            @(posedge clock_i);
        end
        // The read is sampled seven counts after the reset to zero
        if (chk) begin
            chk_rd(`OFS_LMFC_COUNT, 32'(7 % (last + 1)), "lmfc_read");
        end
    endtask

    initial begin
        rst_b_i = 1'b0;
        req = '0;
        lanes_set = '0;
        sref_req = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        rows[0] = {16'he4a1, 8'h01, 8'h80, 8'h55, 8'haa, 32'he4a1, 32'h0001_0080, 32'h0055_00aa};
        rows[1] = {16'hffff, {4{8'hff}}, 32'hffff, 32'h00ff_00ff, 32'h00ff_00ff};
        rows[2] = '0;
        rows[3] = {16'h1b00, 8'h80, 8'h01, 8'h0f, 8'hf0, 32'h1b00, 32'h0080_0001, 32'h000f_00f0};
        repeat (12) @(posedge clock_i);
        #1 `CHK("rdata_rst", 32'h0, rdata_w)
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        chk_rd(`OFS_FRAME_SYNC, 32'h0, "frame_sync_rst");
        chk_rd(`OFS_LANE_FIFO, 32'h0, "fifo_rst");
        chk_rd(`OFS_ALIGN_PHASE, 32'h0, "align_rst");
        chk_rd(`OFS_LINK_CTRL, 32'h0000_0701, "link_ctrl_rst");
        chk_rd(`OFS_IRQ_ENABLE, 32'h0, "irq_en_rst");
        foreach (rows[i]) begin
            @(posedge clock_i);
            lanes_set <= rows[i].l;
            repeat (3) @(posedge clock_i);
            chk_rd(`OFS_FRAME_SYNC, rows[i].fs, "frame_sync");
            chk_rd(`OFS_LANE_FIFO, rows[i].fifo, "lane_fifo");
            chk_rd(`OFS_ALIGN_PHASE, rows[i].algn, "align_phase");
        end
        // Writes to a status word must not stick
        wr(`OFS_LANE_FIFO, 32'hffff_ffff);
        chk_rd(`OFS_LANE_FIFO, 32'h0080_0001, "fifo_ro");
        chk_rd(12'h200, 32'h0, "unmapped");
        chk_rd(`OFS_IRQ_STATUS, 32'h6, "irq_status");
        `CHK("irq_masked", 1'b0, irq_w)
        wr(`OFS_IRQ_ENABLE, 32'h4);
        #1 `CHK("irq_on", 1'b1, irq_w)
        wr(`OFS_IRQ_CLEAR, 32'h7);
        #1 `CHK("irq_off", 1'b0, irq_w)
        sysref_run(7, 1'b1);
        sysref_run(7, 1'b1);
        chk_rd(`OFS_IRQ_STATUS, 32'h1, "irq_sysref");
        `CHK("irq_sref_masked", 1'b0, irq_w)
        wr(`OFS_IRQ_ENABLE, 32'h1);
        #1 `CHK("irq_sref_on", 1'b1, irq_w)
        wr(`OFS_LINK_CTRL, 32'h0000_0301);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        sysref_run(3, 1'b1);
        wr(`OFS_LINK_CTRL, 32'h0000_0700);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        #1 `CHK("irq_sref_off", 1'b0, irq_w)
        sysref_run(7, 1'b0);
        repeat (3) @(posedge clock_i);
        chk_rd(`OFS_IRQ_STATUS, 32'h0, "sub1_off");
        // Second reset in mid-run acts without a clock edge
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        #1 `CHK("lmfc_rst2", 8'h0, lmfc_w)
        `CHK("irq_rst2", 1'b0, irq_w)
        `CHK("rdata_rst2", 32'h0, rdata_w)
        // Release again: written controls fall back, lane copies rise and raise events
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        chk_rd(`OFS_LINK_CTRL, 32'h0000_0701, "link_ctrl_rst2");
        chk_rd(`OFS_IRQ_ENABLE, 32'h0, "irq_en_rst2");
        chk_rd(`OFS_LANE_FIFO, 32'h0080_0001, "fifo_rst2");
        chk_rd(`OFS_IRQ_STATUS, 32'h6, "irq_status_rst2");
        end_sim();
    end
endmodule
